//--- rtl/atm_regs.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "atm_cfg.svh"
module atm_regs
  import atm_pkg::*;
#(
  parameter int ADC_W = 8,
  parameter int TRIM_W = 4,
  parameter int LVL_W = 6,
  parameter int SEG_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic set_default,
  input wire logic conv_done,
  input wire logic [ADC_W-1:0] conv_data,
  input wire logic trim_cal_done,
  input wire logic [TRIM_W-1:0] trim_cal_code,
  input wire logic trim_cal_fail,
  input wire logic mod_cal_done,
  input wire logic [LVL_W-1:0] mod_cal_level,
  input wire logic [SEG_W-1:0] modulated_segment_mask,
  output logic [TRIM_W-1:0] tuning_switch_pins_1,
  output logic [TRIM_W-1:0] tuning_switch_pins_2,
  output atm_pkg::atm_byte_t phase_target,
  output logic am_use_mask,
  output logic [LVL_W-1:0] am_auto_level,
  output logic [SEG_W-1:0] am_seg_disable,
  output logic irq
);
  import atm_pkg::*;

  // Field widths are fixed by the register layout
  if (ADC_W != 8 || TRIM_W != 4 || LVL_W != 6 || SEG_W != 8) begin : g_bad_w
    $error("atm_regs: field widths are fixed by the register layout");
  end

  atm_byte_t conv_r;
  atm_byte_t trim_ctrl_r;
  atm_byte_t phase_r;
  atm_byte_t trim_res_r;
  atm_byte_t am_ctrl_r;
  atm_irq_t irq_stat_r;
  atm_irq_t irq_en_r;
  atm_irq_t irq_ev;
  logic dp_wr_r;
  logic [31:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic aphase;
  logic wr_trim;
  logic wr_phase;
  logic wr_am;
  logic wr_en;
  logic wr_clr;

  // True when a byte address selects the register at this index
  function automatic logic atm_hit(input logic [31:0] a,
                                   input atm_byte_t idx);
    atm_hit = (a == {22'h0, idx, 2'b00});
  endfunction

  // Read value of the register at an address; unmapped reads zero
  function automatic logic [31:0] atm_read(input logic [31:0] a);
    atm_read = 32'h0;
    if (atm_hit(a, `ATM_IDX_CONV)) begin
      atm_read[7:0] = conv_r;
    end else if (atm_hit(a, `ATM_IDX_TRIM_CTRL)) begin
      atm_read[7:0] = trim_ctrl_r & `ATM_TRIM_CTRL_MASK;
    end else if (atm_hit(a, `ATM_IDX_PHASE)) begin
      atm_read[7:0] = phase_r;
    end else if (atm_hit(a, `ATM_IDX_TRIM_RES)) begin
      atm_read[7:0] = trim_res_r & `ATM_TRIM_RES_MASK;
    end else if (atm_hit(a, `ATM_IDX_AM_CTRL)) begin
      atm_read[7:0] = am_ctrl_r & `ATM_AM_CTRL_MASK;
    end else if (atm_hit(a, `ATM_IDX_IRQ_STAT)) begin
      atm_read[3:0] = irq_stat_r;
    end else if (atm_hit(a, `ATM_IDX_IRQ_EN)) begin
      atm_read[3:0] = irq_en_r;
    end
  endfunction

  // Zero-wait slave: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = `ATM_HRESP_OKAY;
  assign hrdata = hrdata_r;
  assign aphase = hsel & htrans[1] & hready;

  assign wr_trim = dp_wr_r & atm_hit(dp_addr_r, `ATM_IDX_TRIM_CTRL);
  assign wr_phase = dp_wr_r & atm_hit(dp_addr_r, `ATM_IDX_PHASE);
  assign wr_am = dp_wr_r & atm_hit(dp_addr_r, `ATM_IDX_AM_CTRL);
  assign wr_en = dp_wr_r & atm_hit(dp_addr_r, `ATM_IDX_IRQ_EN);
  assign wr_clr = dp_wr_r & atm_hit(dp_addr_r, `ATM_IDX_IRQ_CLR);

  // Address phase capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 32'h0;
    end else if (hready) begin
      dp_wr_r <= aphase & hwrite;
      dp_addr_r <= haddr;
    end
  end

  // Read data is fetched at the address phase edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0;
    end else if (aphase & ~hwrite) begin
      hrdata_r <= atm_read(haddr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_r <= `ATM_RST_CONV;
    end else if (set_default) begin
      conv_r <= `ATM_RST_CONV;
    end else if (conv_done) begin
      conv_r <= conv_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_ctrl_r <= `ATM_RST_TRIM_CTRL;
    end else if (set_default) begin
      trim_ctrl_r <= `ATM_RST_TRIM_CTRL;
    end else if (wr_trim) begin
      trim_ctrl_r <= hwdata[7:0] & `ATM_TRIM_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= `ATM_RST_PHASE;
    end else if (set_default) begin
      phase_r <= `ATM_RST_PHASE;
    end else if (wr_phase) begin
      phase_r <= hwdata[7:0];
    end
  end
  assign phase_target = phase_r;

  // Fail flag from the same run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_res_r <= `ATM_RST_TRIM_RES;
    end else if (set_default) begin
      trim_res_r <= `ATM_RST_TRIM_RES;
    end else if (trim_cal_done) begin
      trim_res_r <= {trim_cal_code, trim_cal_fail, 3'b000};
    end
  end

  // Calibration overrides a same-cycle write to the level field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      am_ctrl_r <= `ATM_RST_AM_CTRL;
    end else if (set_default) begin
      am_ctrl_r <= `ATM_RST_AM_CTRL;
    end else if (mod_cal_done) begin
      am_ctrl_r[`ATM_MOD_HI:`ATM_MOD_LO] <= mod_cal_level;
      if (wr_am) begin
        am_ctrl_r[`ATM_MOD_SRC_BIT] <= hwdata[`ATM_MOD_SRC_BIT];
      end
    end else if (wr_am) begin
      am_ctrl_r <= hwdata[7:0] & `ATM_AM_CTRL_MASK;
    end
  end

  assign irq_ev[ATM_EV_CONV] = conv_done;
  assign irq_ev[ATM_EV_TRIM] = trim_cal_done;
  assign irq_ev[ATM_EV_FAIL] = trim_cal_done & trim_cal_fail;
  assign irq_ev[ATM_EV_MOD] = mod_cal_done;

  // Sticky status; a new event beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < `ATM_NUM_EV; gi++) begin : g_stat
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (irq_ev[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (wr_clr & hwdata[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= `ATM_RST_IRQ;
    end else if (wr_en) begin
      irq_en_r <= hwdata[3:0];
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  atm_trim_mux #(
    .TRIM_W(TRIM_W)
  ) i_atm_trim_mux (
    .clk(clk),
    .rst_n(rst_n),
    .manual_sel(trim_ctrl_r[`ATM_TRIM_SRC_BIT]),
    .manual_trim_bits(trim_ctrl_r[`ATM_MAN_HI:`ATM_MAN_LO]),
    .auto_trim_result(trim_res_r[`ATM_RES_HI:`ATM_RES_LO]),
    .pins_grp1(tuning_switch_pins_1),
    .pins_grp2(tuning_switch_pins_2)
  );

  atm_mod_mux #(
    .LVL_W(LVL_W),
    .SEG_W(SEG_W)
  ) i_atm_mod_mux (
    .clk(clk),
    .rst_n(rst_n),
    .use_mask(am_ctrl_r[`ATM_MOD_SRC_BIT]),
    .auto_mod_level(am_ctrl_r[`ATM_MOD_HI:`ATM_MOD_LO]),
    .modulated_segment_mask(modulated_segment_mask),
    .mask_active(am_use_mask),
    .level_out(am_auto_level),
    .seg_disable(am_seg_disable)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_conv_capture: assert property (
    conv_done && !set_default |=> conv_r == $past(conv_data))
    else $error("conversion result not latched");

  a_conv_readback: assert property (
    aphase && !hwrite && atm_hit(haddr, `ATM_IDX_CONV)
    |=> hrdata == {24'h0, $past(conv_r)})
    else $error("conversion register read wrong");

  a_result_clear: assert property (
    set_default
    |=> conv_r == `ATM_RST_CONV && trim_res_r == `ATM_RST_TRIM_RES)
    else $error("result registers not cleared");

  a_ctrl_default: assert property (
    set_default |=> trim_ctrl_r == `ATM_RST_TRIM_CTRL
    && am_ctrl_r == `ATM_RST_AM_CTRL)
    else $error("control defaults not restored");

  a_trim_auto: assert property (
    !trim_ctrl_r[`ATM_TRIM_SRC_BIT]
    |=> tuning_switch_pins_1 == $past(trim_res_r[`ATM_RES_HI:`ATM_RES_LO]))
    else $error("trim pins not from calibration result");

  a_trim_manual: assert property (
    trim_ctrl_r[`ATM_TRIM_SRC_BIT]
    |=> tuning_switch_pins_1 == $past(trim_ctrl_r[`ATM_MAN_HI:`ATM_MAN_LO])
    && tuning_switch_pins_2 == tuning_switch_pins_1)
    else $error("trim pins not from manual bits");

  a_pins_twin: assert property (
    tuning_switch_pins_1 == tuning_switch_pins_2)
    else $error("trim pin groups differ");

  // A write right after set-default may replace the default
  a_phase_target: assert property (
    set_default |=> phase_target == `ATM_RST_PHASE
    ##1 ($past(wr_phase) || phase_target == `ATM_RST_PHASE))
    else $error("phase target default wrong");

  a_phase_write: assert property (
    wr_phase && !set_default |=> phase_target == $past(hwdata[7:0]))
    else $error("phase target write lost");

  a_trim_store: assert property (
    trim_cal_done && !set_default
    |=> trim_res_r[`ATM_RES_HI:`ATM_RES_LO] == $past(trim_cal_code))
    else $error("calibration result not stored");

  a_fail_flag: assert property (
    trim_cal_done && trim_cal_fail && !set_default
    |=> trim_res_r[`ATM_FAIL_BIT] && irq_stat_r[ATM_EV_FAIL])
    else $error("calibration fail flag missing");

  a_mod_level: assert property (
    mod_cal_done && !set_default
    |=> am_ctrl_r[`ATM_MOD_HI:`ATM_MOD_LO] == $past(mod_cal_level)
    ##1 (am_use_mask || am_auto_level == $past(am_ctrl_r[6:1])))
    else $error("automatic modulation level wrong");

  a_mod_source: assert property (
    !am_ctrl_r[`ATM_MOD_SRC_BIT]
    |=> !am_use_mask && am_seg_disable == 8'h00)
    else $error("segment mask active in automatic mode");

  a_seg_mask: assert property (
    am_ctrl_r[`ATM_MOD_SRC_BIT]
    |=> am_use_mask && am_seg_disable == $past(modulated_segment_mask))
    else $error("segment mask not applied");

  a_unused_zero: assert property (
    aphase && !hwrite && (atm_hit(haddr, `ATM_IDX_TRIM_CTRL)
    || atm_hit(haddr, `ATM_IDX_TRIM_RES)) |=> hrdata[2:0] == 3'h0)
    else $error("unused bits read nonzero");

  a_am_unused: assert property (
    aphase && !hwrite && atm_hit(haddr, `ATM_IDX_AM_CTRL)
    |=> hrdata[31:8] == 24'h0 && !hrdata[0])
    else $error("unused modulation bits read nonzero");

  a_irq_level: assert property (
    $rose(irq_stat_r[ATM_EV_CONV]) && irq_en_r[ATM_EV_CONV] |-> irq)
    else $error("enabled status did not raise interrupt");

  c_manual_trim: cover property (wr_trim && hwdata[7]);
  c_trim_fail: cover property (trim_cal_done && trim_cal_fail);
  c_mod_cal: cover property (mod_cal_done ##1 irq);
  c_mask_mode: cover property (wr_am && hwdata[7]);
  c_set_default: cover property (set_default ##1 !set_default);
endmodule

//--- rtl/atm_cfg.svh
`ifndef ATM_CFG_SVH
`define ATM_CFG_SVH
// Register indices; byte address is four times the index
`define ATM_IDX_CONV 8'h20
`define ATM_IDX_TRIM_CTRL 8'h21
`define ATM_IDX_PHASE 8'h22
`define ATM_IDX_TRIM_RES 8'h23
`define ATM_IDX_AM_CTRL 8'h24
`define ATM_IDX_IRQ_STAT 8'h30
`define ATM_IDX_IRQ_EN 8'h31
`define ATM_IDX_IRQ_CLR 8'h32
// Reset and default values
`define ATM_RST_CONV 8'h00
`define ATM_RST_TRIM_CTRL 8'h00
`define ATM_RST_PHASE 8'h80
`define ATM_RST_TRIM_RES 8'h00
`define ATM_RST_AM_CTRL 8'h00
`define ATM_RST_IRQ 4'h0
// Field positions
`define ATM_TRIM_SRC_BIT 7
`define ATM_MAN_HI 6
`define ATM_MAN_LO 3
`define ATM_RES_HI 7
`define ATM_RES_LO 4
`define ATM_FAIL_BIT 3
`define ATM_MOD_SRC_BIT 7
`define ATM_MOD_HI 6
`define ATM_MOD_LO 1
// Implemented bits of the trim control, trim result and modulation control registers
`define ATM_TRIM_CTRL_MASK 8'hf8
`define ATM_TRIM_RES_MASK 8'hf8
`define ATM_AM_CTRL_MASK 8'hfe
// Bus encodings and interrupt event count
`define ATM_HSIZE_WORD 3'h2
`define ATM_HRESP_OKAY 1'b0
`define ATM_NUM_EV 4
`endif

//--- rtl/atm_pkg.sv
package atm_pkg;
  typedef logic [7:0] atm_byte_t;
  typedef logic [3:0] atm_trim_t;
  typedef logic [5:0] atm_level_t;
  typedef logic [3:0] atm_irq_t;
  // Interrupt status bit positions
  typedef enum logic [1:0] {
    ATM_EV_CONV,
    ATM_EV_TRIM,
    ATM_EV_FAIL,
    ATM_EV_MOD
  } atm_event_t;
endpackage

//--- rtl/atm_trim_mux.sv
`timescale 1ns/10ps
module atm_trim_mux #(
  parameter int TRIM_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manual_sel,
  input wire logic [TRIM_W-1:0] manual_trim_bits,
  input wire logic [TRIM_W-1:0] auto_trim_result,
  output logic [TRIM_W-1:0] pins_grp1,
  output logic [TRIM_W-1:0] pins_grp2
);
  // Same switch pattern on both groups
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_grp1 <= '0;
      pins_grp2 <= '0;
    end else begin
      pins_grp1 <= manual_sel ? manual_trim_bits : auto_trim_result;
      pins_grp2 <= manual_sel ? manual_trim_bits : auto_trim_result;
    end
  end
endmodule

//--- rtl/atm_mod_mux.sv
`timescale 1ns/10ps
module atm_mod_mux #(
  parameter int LVL_W = 6,
  parameter int SEG_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic use_mask,
  input wire logic [LVL_W-1:0] auto_mod_level,
  input wire logic [SEG_W-1:0] modulated_segment_mask,
  output logic mask_active,
  output logic [LVL_W-1:0] level_out,
  output logic [SEG_W-1:0] seg_disable
);
  // Mask disables segments only in mask mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_active <= 1'b0;
      level_out <= '0;
      seg_disable <= '0;
    end else begin
      mask_active <= use_mask;
      level_out <= use_mask ? '0 : auto_mod_level;
      seg_disable <= use_mask ? modulated_segment_mask : '0;
    end
  end
endmodule

//--- bench/atm_regs_tb.sv
`timescale 1ns/10ps
module atm_regs_tb;
  import atm_pkg::*;
  localparam logic [31:0] A_CONV = 32'h80;
  localparam logic [31:0] A_TCTL = 32'h84;
  localparam logic [31:0] A_PHS = 32'h88;
  localparam logic [31:0] A_TRES = 32'h8c;
  localparam logic [31:0] A_AM = 32'h90;
  localparam logic [31:0] A_IST = 32'hc0;
  localparam logic [31:0] A_IEN = 32'hc4;
  localparam logic [31:0] A_ICLR = 32'hc8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  wire hready = hreadyout;
  logic set_default = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] conv_data = 8'h0;
  logic trim_cal_done = 1'b0;
  logic [3:0] trim_cal_code = 4'h0;
  logic trim_cal_fail = 1'b0;
  logic mod_cal_done = 1'b0;
  logic [5:0] mod_cal_level = 6'h0;
  logic [7:0] seg_mask = 8'h3c;
  logic [3:0] pins1;
  logic [3:0] pins2;
  atm_byte_t phase_target;
  logic am_use_mask;
  logic [5:0] am_auto_level;
  logic [7:0] am_seg_disable;
  logic irq;
  int n_errors = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  atm_regs i_atm_regs (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .set_default(set_default),
    .conv_done(conv_done), .conv_data(conv_data),
    .trim_cal_done(trim_cal_done), .trim_cal_code(trim_cal_code),
    .trim_cal_fail(trim_cal_fail), .mod_cal_done(mod_cal_done),
    .mod_cal_level(mod_cal_level), .modulated_segment_mask(seg_mask),
    .tuning_switch_pins_1(pins1), .tuning_switch_pins_2(pins2),
    .phase_target(phase_target), .am_use_mask(am_use_mask),
    .am_auto_level(am_auto_level), .am_seg_disable(am_seg_disable),
    .irq(irq));

  task automatic conclude;
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Outputs follow the registers one edge later; sample off the edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic [3:0] exp);
    settle();
    chk({28'h0, pins1}, {28'h0, exp});
    chk({28'h0, pins2}, {28'h0, exp});
  endtask

  task automatic t_reset;
    rdchk(A_CONV, 32'h00);
    rdchk(A_TRES, 32'h00);
    rdchk(A_TCTL, 32'h00);
    rdchk(A_PHS, 32'h80);
    rdchk(A_AM, 32'h00);
    pins(4'h0);
    chk({24'h0, phase_target}, 32'h80);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_conv;
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= 8'ha5;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_data <= 8'h5a;
    rdchk(A_CONV, 32'ha5);
    wr(A_CONV, 32'h11);
    rdchk(A_CONV, 32'ha5);
  endtask

  task automatic t_trim;
    @(posedge clk);
    trim_cal_done <= 1'b1;
    trim_cal_code <= 4'h9;
    trim_cal_fail <= 1'b1;
    @(posedge clk);
    trim_cal_done <= 1'b0;
    trim_cal_code <= 4'h0;
    trim_cal_fail <= 1'b0;
    rdchk(A_TRES, 32'h98);
    pins(4'h9);
    wr(A_TCTL, 32'hff);
    rdchk(A_TCTL, 32'hf8);
    pins(4'hf);
    wr(A_TCTL, 32'hb0);
    pins(4'h6);
    wr(A_TCTL, 32'h30);
    pins(4'h9);
    wr(A_TRES, 32'h00);
    rdchk(A_TRES, 32'h98);
  endtask

  task automatic t_mod;
    @(posedge clk);
    mod_cal_done <= 1'b1;
    mod_cal_level <= 6'h2d;
    @(posedge clk);
    mod_cal_done <= 1'b0;
    rdchk(A_AM, 32'h5a);
    settle();
    chk({26'h0, am_auto_level}, 32'h2d);
    chk({24'h0, am_seg_disable}, 32'h00);
    wr(A_AM, 32'hff);
    rdchk(A_AM, 32'hfe);
    settle();
    chk({31'h0, am_use_mask}, 32'h1);
    chk({24'h0, am_seg_disable}, 32'h3c);
    chk({26'h0, am_auto_level}, 32'h00);
    // Mask changes must reach the segments in mask mode
    @(posedge clk);
    seg_mask <= 8'hc3;
    settle();
    chk({24'h0, am_seg_disable}, 32'hc3);
  endtask

  task automatic t_phase;
    wr(A_PHS, 32'h37);
    rdchk(A_PHS, 32'h37);
    settle();
    chk({24'h0, phase_target}, 32'h37);
    rdchk(32'hfc, 32'h0);
  endtask

  task automatic t_irq;
    rdchk(A_IST, 32'hf);
    wr(A_IEN, 32'h1);
    rdchk(A_IEN, 32'h1);
    wr(A_ICLR, 32'h1);
    rdchk(A_IST, 32'he);
    settle();
    chk({31'h0, irq}, 32'h0);
    t_conv();
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(A_ICLR, 32'hf);
    rdchk(A_ICLR, 32'h0);
    rdchk(A_IST, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_setdef;
    @(posedge clk);
    set_default <= 1'b1;
    @(posedge clk);
    set_default <= 1'b0;
    rdchk(A_CONV, 32'h00);
    rdchk(A_TRES, 32'h00);
    rdchk(A_TCTL, 32'h00);
    rdchk(A_PHS, 32'h80);
    rdchk(A_AM, 32'h00);
    rdchk(A_IEN, 32'h1);
    pins(4'h0);
    chk({31'h0, am_use_mask}, 32'h0);
    chk({24'h0, am_seg_disable}, 32'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_trim();
    t_mod();
    t_phase();
    t_irq();
    t_setdef();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule
